//--- accpfx_pkg.sv
// package: constants and carriers for accumulator three and prefix block
package accpfx_pkg;
  localparam int unsigned DATA_W = 16;
  localparam logic [15:0] ACC3_RST = 16'h0000;
  localparam logic [15:0] PFX_RST  = 16'h0000;
  localparam int unsigned PFX_LO_W = 8;
  localparam int unsigned PFX_HI_LSB = 8;
  localparam logic [3:0] PFX_EXT_MIN = 4'h1;
  localparam logic [3:0] PFX_EXT_MAX = 4'h7;
  // register map byte addresses (word aligned)
  localparam logic [7:0] ADDR_ACC3   = 8'h00;
  localparam logic [7:0] ADDR_PFX    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_XFER   = 8'h0c;
  localparam logic [7:0] ADDR_RESULT = 8'h10;
  localparam logic [7:0] ADDR_SEL    = 8'h14;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] ACC3_SEL_CODE = 2'h3;

  typedef struct packed {
    logic [15:0] acc3;
    logic [7:0]  pfx_lo;
    logic        pfx_armed;
    logic [1:0]  acc_ptr;
  } accpfx_state_s;

  typedef struct packed {
    logic [7:0]  src8;
    logic [2:0]  ext_src;
    logic [2:0]  ext_dst;
  } accpfx_xfer_s;
endpackage

//--- accpfx_axil.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/100ps
module accpfx_axil
  import accpfx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  output logic             wr_o,
  output logic [7:0]       wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic [3:0]       wr_strb_o,
  input  wire logic        wr_ok_i,
  output logic             rd_o,
  output logic [7:0]       rd_addr_o,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        rd_ok_i
);
  logic        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;

  assign awready_o = !aw_r && !b_r;
  assign wready_o  = !w_r && !b_r;
  assign arready_o = !r_r;
  assign bvalid_o  = b_r;
  assign bresp_o   = br_r;
  assign rvalid_o  = r_r;
  assign rresp_o   = rr_r;
  assign rdata_o   = rd_r;
  assign wr_o      = aw_r && w_r && !b_r;
  assign wr_addr_o = awa_r;
  assign wr_data_o = wd_r;
  assign wr_strb_o = ws_r;
  assign rd_o      = arvalid_i && !r_r;
  assign rd_addr_o = araddr_i;

  always_comb begin
    aw_nxt = aw_r; w_nxt = w_r; b_nxt = b_r; r_nxt = r_r;
    awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r;
    br_nxt = br_r; rr_nxt = rr_r; rd_nxt = rd_r;
    if (awvalid_i && awready_o) begin
      aw_nxt = 1'b1; awa_nxt = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      w_nxt = 1'b1; wd_nxt = wdata_i; ws_nxt = wstrb_i;
    end
    if (wr_o) begin
      aw_nxt = 1'b0; w_nxt = 1'b0; b_nxt = 1'b1;
      br_nxt = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
    end
    if (b_r && bready_i) b_nxt = 1'b0;
    if (rd_o) begin
      r_nxt = 1'b1; rd_nxt = rd_data_i;
      rr_nxt = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
    end
    if (r_r && rready_i) r_nxt = 1'b0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_r <= 1'b0; w_r <= 1'b0; b_r <= 1'b0; r_r <= 1'b0;
      awa_r <= 8'h00; wd_r <= 32'h0000_0000; ws_r <= 4'h0;
      br_r <= RESP_OKAY; rr_r <= RESP_OKAY; rd_r <= 32'h0000_0000;
    end else begin
      aw_r <= aw_nxt; w_r <= w_nxt; b_r <= b_nxt; r_r <= r_nxt;
      awa_r <= awa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
      br_r <= br_nxt; rr_r <= rr_nxt; rd_r <= rd_nxt;
    end
  end
endmodule // accpfx_axil

//--- accpfx_regs.sv
// accumulator three and one-shot prefix register with AXI4-Lite access
// Function
// - every reset clears accumulator three and prefix register to zero
// - accumulator three is free read/write, working or selected accumulator
// - prefix write arms it; a transfer write that is the next bus write gets low byte on top of 8-bit source
// - prefix keeps its value until the next bus write, then clears itself
// - prefix read while not armed delivers zero
// - prefix bits 15:8 are reserved and read zero
// - prefix subdecodes one to seven extend source/destination index
`timescale 1ns/100ps
module accpfx_regs
  import accpfx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  s_axil_awaddr_i,
  input  wire logic        s_axil_awvalid_i,
  output logic             s_axil_awready_o,
  input  wire logic [31:0] s_axil_wdata_i,
  input  wire logic [3:0]  s_axil_wstrb_i,
  input  wire logic        s_axil_wvalid_i,
  output logic             s_axil_wready_o,
  output logic [1:0]       s_axil_bresp_o,
  output logic             s_axil_bvalid_o,
  input  wire logic        s_axil_bready_i,
  input  wire logic [7:0]  s_axil_araddr_i,
  input  wire logic        s_axil_arvalid_i,
  output logic             s_axil_arready_o,
  output logic [31:0]      s_axil_rdata_o,
  output logic [1:0]       s_axil_rresp_o,
  output logic             s_axil_rvalid_o,
  input  wire logic        s_axil_rready_i,
  output logic [15:0]      acc3_o,
  output logic             acc3_active_o,
  output logic [2:0]       ext_src_o,
  output logic [2:0]       ext_dst_o
);
  logic        wr, rd, wr_ok, rd_ok;
  logic [7:0]  wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;
  accpfx_state_s st_r, st_nxt;
  accpfx_xfer_s  xf_r, xf_nxt;
  logic [15:0]   res_r, res_nxt;
  logic [3:0]    pfx_sub_r, pfx_sub_nxt;
  logic          pfx_rd_hit;

  accpfx_axil u_bus (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .awaddr_i  (s_axil_awaddr_i),
    .awvalid_i (s_axil_awvalid_i),
    .awready_o (s_axil_awready_o),
    .wdata_i   (s_axil_wdata_i),
    .wstrb_i   (s_axil_wstrb_i),
    .wvalid_i  (s_axil_wvalid_i),
    .wready_o  (s_axil_wready_o),
    .bresp_o   (s_axil_bresp_o),
    .bvalid_o  (s_axil_bvalid_o),
    .bready_i  (s_axil_bready_i),
    .araddr_i  (s_axil_araddr_i),
    .arvalid_i (s_axil_arvalid_i),
    .arready_o (s_axil_arready_o),
    .rdata_o   (s_axil_rdata_o),
    .rresp_o   (s_axil_rresp_o),
    .rvalid_o  (s_axil_rvalid_o),
    .rready_i  (s_axil_rready_i),
    .wr_o      (wr),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_ok_i   (wr_ok),
    .rd_o      (rd),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_ok_i   (rd_ok)
  );

  assign wr_ok = (wr_addr == ADDR_ACC3) || (wr_addr == ADDR_PFX)
              || (wr_addr == ADDR_XFER) || (wr_addr == ADDR_SEL);
  assign rd_ok = (rd_addr <= ADDR_SEL) && (rd_addr[1:0] == 2'b00);
  assign pfx_rd_hit = rd && (rd_addr == ADDR_PFX);

  // read mux; prefix upper byte always zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      ADDR_ACC3:   rd_data[15:0] = st_r.acc3;
      ADDR_PFX:    rd_data[15:0] = st_r.pfx_armed ?
                     {8'h00, st_r.pfx_lo} : 16'h0000;
      ADDR_STATUS: rd_data[7:0] = {3'h0, pfx_sub_r, st_r.pfx_armed};
      ADDR_RESULT: rd_data[15:0] = res_r;
      ADDR_SEL:    rd_data[1:0] = st_r.acc_ptr;
      default:     rd_data = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    xf_nxt = xf_r;
    res_nxt = res_r;
    pfx_sub_nxt = pfx_sub_r;
    // one-shot: the next bus write, whatever its target, uses up the prefix;
    // a per-clock one-shot could never be seen across the bus
    if (st_r.pfx_armed && wr) begin
      st_nxt.pfx_armed = 1'b0;
      st_nxt.pfx_lo = 8'h00;
      pfx_sub_nxt = 4'h0;
    end
    // reading consumes nothing; an armed prefix is used up by the next bus write
    if (wr) begin
      unique case (wr_addr)
        ADDR_ACC3: begin
          if (wr_strb[0]) st_nxt.acc3[7:0] = wr_data[7:0];
          if (wr_strb[1]) st_nxt.acc3[15:8] = wr_data[15:8];
        end
        ADDR_PFX: begin
          st_nxt.pfx_armed = 1'b1;
          st_nxt.pfx_lo = wr_strb[0] ? wr_data[7:0] : 8'h00;
          // subdecode in bits 19:16 of the write word
          pfx_sub_nxt = wr_data[19:16];
        end
        ADDR_XFER: begin
          xf_nxt.src8 = wr_data[7:0];
          // prefix high byte only if armed the instruction before
          res_nxt = {st_r.pfx_armed ? st_r.pfx_lo : 8'h00,
                     wr_data[7:0]};
          if (st_r.pfx_armed && pfx_sub_r >= PFX_EXT_MIN
              && pfx_sub_r <= PFX_EXT_MAX) begin
            xf_nxt.ext_src = pfx_sub_r[2:0];
            xf_nxt.ext_dst = pfx_sub_r[2:0];
          end else begin
            xf_nxt.ext_src = 3'h0;
            xf_nxt.ext_dst = 3'h0;
          end
        end
        ADDR_SEL: st_nxt.acc_ptr = wr_data[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '{acc3: ACC3_RST, pfx_lo: PFX_RST[7:0], pfx_armed: 1'b0,
                acc_ptr: 2'h0};
      xf_r <= '0;
      res_r <= 16'h0000;
      pfx_sub_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      xf_r <= xf_nxt;
      res_r <= res_nxt;
      pfx_sub_r <= pfx_sub_nxt;
    end
  end

  assign acc3_o = st_r.acc3;
  assign acc3_active_o = (st_r.acc_ptr == ACC3_SEL_CODE);
  assign ext_src_o = xf_r.ext_src;
  assign ext_dst_o = xf_r.ext_dst;

  sequence s_pfx_wr;
    wr && wr_addr == ADDR_PFX;
  endsequence
  sequence s_pfx_used;
    st_r.pfx_armed && wr && wr_addr != ADDR_PFX;
  endsequence
  sequence s_xfer_wr;
    wr && wr_addr == ADDR_XFER;
  endsequence

  a_pfx_one_shot: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_pfx_used |=> !st_r.pfx_armed)
    else $error("prefix stayed armed");
  a_pfx_clears: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_pfx_used |=> st_r.pfx_lo == 8'h00 && pfx_sub_r == 4'h0)
    else $error("prefix value not cleared");
  a_pfx_holds: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (st_r.pfx_armed && !wr) |=>
      st_r.pfx_armed && $stable(st_r.pfx_lo))
    else $error("prefix lost before use");
  a_pfx_arms: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_pfx_wr |=> st_r.pfx_armed)
    else $error("prefix write did not arm");
  a_pfx_rd_zero: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (pfx_rd_hit && !st_r.pfx_armed) |=> s_axil_rdata_o == 32'h0)
    else $error("unarmed prefix read not zero");
  a_pfx_rd_byte: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (pfx_rd_hit && st_r.pfx_armed) |=>
      s_axil_rdata_o == {24'h00_0000, $past(st_r.pfx_lo)})
    else $error("armed prefix read wrong");
  a_pfx_hi_zero: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    pfx_rd_hit |=> s_axil_rdata_o[31:8] == 24'h00_0000)
    else $error("prefix high byte not zero");
  a_xfer_concat: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    s_xfer_wr |=> res_r == {($past(st_r.pfx_armed) ? $past(st_r.pfx_lo)
                             : 8'h00), $past(wr_data[7:0])})
    else $error("transfer result wrong");
  a_ext_bits: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr && wr_addr == ADDR_XFER && !st_r.pfx_armed) |=>
      ext_src_o == 3'h0 && ext_dst_o == 3'h0)
    else $error("extension without prefix");
  a_ext_copy: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr && wr_addr == ADDR_XFER && st_r.pfx_armed
      && pfx_sub_r >= PFX_EXT_MIN && pfx_sub_r <= PFX_EXT_MAX) |=>
      ext_src_o == $past(pfx_sub_r[2:0])
      && ext_dst_o == $past(pfx_sub_r[2:0]))
    else $error("extension bits not taken");
  a_acc3_write: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr && wr_addr == ADDR_ACC3 && wr_strb[1:0] == 2'b11) |=>
      acc3_o == $past(wr_data[15:0]))
    else $error("accumulator write lost");
  a_acc3_keep: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !(wr && wr_addr == ADDR_ACC3) |=> $stable(acc3_o))
    else $error("accumulator changed without write");
  a_reset_vals: assert property (
    @(posedge clk_i)
    $fell(sys_rst_i) |->
      acc3_o == 16'h0000 && !st_r.pfx_armed && st_r.pfx_lo == 8'h00)
    else $error("reset values wrong");
endmodule // accpfx_regs

//--- accpfx_core_model.sv
// core side model: drives register bus cycles for the bench
`timescale 1ns/100ps
module accpfx_core_model
  import accpfx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        awready_i,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output logic [7:0]       awaddr_o,
  output logic             awvalid_o,
  output logic [31:0]      wdata_o,
  output logic [3:0]       wstrb_o,
  output logic             wvalid_o,
  output logic             bready_o,
  output logic [7:0]       araddr_o,
  output logic             arvalid_o,
  output logic             rready_o,
  output logic             hang_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
    {bready_o, araddr_o, arvalid_o, rready_o, hang_o} = '0;
  end
  // one word per call; released payload is scrambled, not left stale
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    // one edge between calls: no strobe changes twice in one step
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      if (bvalid_i) break;
    end
    bready_o <= 1'b0;
    r = bresp_i;
    if (n == 50) hang_o <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      if (rvalid_i) break;
    end
    rready_o <= 1'b0;
    d = rdata_i;
    r = rresp_i;
    if (n == 50) hang_o <= 1'b1;
  endtask
endmodule // accpfx_core_model

//--- tb_accumulator_and_prefix_regs.sv
// self-checking bench for accumulator three and prefix registers
`timescale 1ns/100ps
module tb_accumulator_and_prefix_regs
  import accpfx_pkg::*;
;
  logic        clk, rst, hang;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [15:0] acc3, acc;
  logic        act;
  logic [2:0]  xs, xd;
  int          errors, cmp_count, seed, i;
  int          m_arm, m_pfx, m_sub, x, e;
  int          exp_q[$];
  initial clk = 1'b0;
  always #10 clk = ~clk;
  accpfx_regs accpfx_regs_inst (.clk_i(clk), .sys_rst_i(rst),
    .s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awv),
    .s_axil_awready_o(awr), .s_axil_wdata_i(wdata),
    .s_axil_wstrb_i(wstrb), .s_axil_wvalid_i(wv), .s_axil_wready_o(wr),
    .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bv), .s_axil_bready_i(br),
    .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arv),
    .s_axil_arready_o(arr), .s_axil_rdata_o(rdata),
    .s_axil_rresp_o(rresp), .s_axil_rvalid_o(rv), .s_axil_rready_i(rr),
    .acc3_o(acc3), .acc3_active_o(act), .ext_src_o(xs), .ext_dst_o(xd));
  accpfx_core_model accpfx_core_model_inst (.clk_i(clk),
    .awready_i(awr), .wready_i(wr), .bresp_i(bresp), .bvalid_i(bv),
    .arready_i(arr), .rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rv),
    .awaddr_o(awaddr), .awvalid_o(awv), .wdata_o(wdata), .wstrb_o(wstrb),
    .wvalid_o(wv), .bready_o(br), .araddr_o(araddr), .arvalid_o(arv),
    .rready_o(rr), .hang_o(hang));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // integer reference model of the prefix path
  task automatic load_pfx(input logic [31:0] v);
    accpfx_core_model_inst.wr(ADDR_PFX, v, r);
    m_arm = 1;
    m_pfx = v[7:0];
    m_sub = v[19:16];
  endtask
  task automatic xfer(input logic [31:0] v);
    accpfx_core_model_inst.wr(ADDR_XFER, v, r);
    exp_q.push_back(m_arm ? (m_pfx << 8) | v[7:0] : v[7:0]);
    e = (m_arm && m_sub >= 1 && m_sub <= 7) ? m_sub : 0;
    m_arm = 0;
    m_pfx = 0;
    m_sub = 0;
  endtask
  task automatic check_pfx();
    accpfx_core_model_inst.rd(ADDR_PFX, q, r);
    chk(q, m_arm ? m_pfx : 0);
    accpfx_core_model_inst.rd(ADDR_STATUS, q, r);
    chk(q, m_arm ? (m_sub << 1) | 1 : 0);
  endtask
  task automatic check_xfer();
    accpfx_core_model_inst.rd(ADDR_RESULT, q, r);
    chk(q, exp_q.pop_front());
    chk({26'h0, xs, xd}, (e << 3) | e);
  endtask
  always @(posedge hang) begin
    errors++;
    tally_and_finish();
  end
  initial begin
    errors = 0;
    cmp_count = 0;
    seed = 32'hc00c;
    m_arm = 0;
    m_pfx = 0;
    m_sub = 0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    accpfx_core_model_inst.rd(ADDR_ACC3, q, r);
    chk(q, 32'h0);
    accpfx_core_model_inst.rd(ADDR_PFX, q, r);
    chk(q, 32'h0);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      x = $random(seed);
      acc = d[15:0];
      accpfx_core_model_inst.wr(ADDR_ACC3, d, r);
      accpfx_core_model_inst.rd(ADDR_ACC3, q, r);
      chk(q, {16'h0, acc});
      chk({16'h0, acc3}, {16'h0, acc});
      // subdecode steps through codes inside and outside one to seven
      d[19:16] = 4'(i * 3);
      load_pfx(d);
      check_pfx();
      xfer(x);
      check_xfer();
      check_pfx();
      xfer(~x);
      check_xfer();
      accpfx_core_model_inst.wr(ADDR_SEL, i, r);
      chk({31'h0, act}, {31'h0, i % 4 == 3});
    end
    accpfx_core_model_inst.wr(8'h40, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    accpfx_core_model_inst.rd(8'h40, q, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    accpfx_core_model_inst.wr(ADDR_STATUS, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    // an armed prefix and a loaded accumulator must both clear
    load_pfx(d);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m_arm = 0;
    m_pfx = 0;
    m_sub = 0;
    accpfx_core_model_inst.rd(ADDR_ACC3, q, r);
    chk(q, 32'h0);
    check_pfx();
    tally_and_finish();
  end
endmodule // tb_accumulator_and_prefix_regs
